// File: bbf_consts.vh
// Constants for the buck-boost frequency and protection configuration block.
// Assumes a 20 MHz core clock and an I2C host on the two serial pins.
`ifndef BBF_CONSTS_VH
`define BBF_CONSTS_VH

// Register offsets
`define BBF_REG_FREQ_PROT   8'h03
`define BBF_REG_AVG_AVERAGE_CURRENT_LIMIT    8'h04

// Reset values, write mask and read-as-zero value
`define BBF_FREQ_PROT_RST   8'h85
`define BBF_AVG_AVERAGE_CURRENT_LIMIT_RST    3'h1
`define BBF_FREQ_PROT_WMASK 8'hDF
`define BBF_RD_ZERO         8'h00

// Field positions in frequency_and_protection_control and the average current limit register
`define BBF_F_BASE_FREQ     7:6
`define BBF_F_TRANS_FREQ    4
`define BBF_F_OC_RESP       3:2
`define BBF_F_OV_RESP       1:0
`define BBF_F_AVERAGE_CURRENT_LIMIT_CODE     2:0

// Response codes
`define BBF_RESP_NONE       2'h0
`define BBF_RESP_AUTO       2'h1
`define BBF_RESP_LATCH      2'h2

// Frequencies in kHz
`define BBF_KHZ_200         10'h0C8
`define BBF_KHZ_300         10'h12C
`define BBF_KHZ_400         10'h190
`define BBF_KHZ_600         10'h258
`define BBF_FREQ_RST_KHZ    10'h190
`define BBF_TRANS_HI_MUL    13'h0005
`define BBF_TRANS_LO_MUL    13'h0003
`define BBF_TRANS_DIV_SH    3

// Average current limit thresholds in units of 0.1 mV
`define BBF_AVERAGE_CURRENT_LIMIT_0          10'h117
`define BBF_AVERAGE_CURRENT_LIMIT_1          10'h14D
`define BBF_AVERAGE_CURRENT_LIMIT_2          10'h189
`define BBF_AVERAGE_CURRENT_LIMIT_3          10'h1C3
`define BBF_AVERAGE_CURRENT_LIMIT_4          10'h200
`define BBF_AVERAGE_CURRENT_LIMIT_5          10'h238
`define BBF_AVERAGE_CURRENT_LIMIT_6          10'h274
`define BBF_AVERAGE_CURRENT_LIMIT_7          10'h2AF

// Frequency slew: one kHz per 20 clocks, 1 us at 20 MHz
`define BBF_SLEW_LAST       5'h13
`define BBF_SLEW_CNT_W      5

// I2C
`define BBF_I2C_ADDR        7'h2A
`define BBF_BIT_CNT_LAST    4'h7
`define BBF_BIT_CNT_FULL    4'h8

`endif

// File: bbf_i2c_slave.v
// I2C target: byte engine with register pointer and auto increment.
// Assumes SCL and SDA are already synchronous to the clock.
`include "bbf_consts.vh"

module bbf_i2c_slave (
	input  wire       clk_in,
	input  wire       rst_b_in,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_out,
	output wire [7:0] reg_addr_out,
	output wire [7:0] wr_data_out,
	output wire       wr_stb_out,
	input  wire [7:0] rd_data_in
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_WR   = 3'h3;
	localparam ST_WACK = 3'h4;
	localparam ST_RD   = 3'h5;
	localparam ST_RACK = 3'h6;

	reg [2:0] state_r;
	reg       scl_d_r;
	reg       sda_d_r;
	reg [3:0] cnt_r;
	reg [7:0] sh_r;
	reg [7:0] tx_r;
	reg [7:0] ptr_r;
	reg       rw_r;
	reg       first_r;
	reg       nack_r;
	reg       oe_r;
	reg       stb_r;

	wire start_w = scl_in & sda_d_r & ~sda_in;
	wire stop_w  = scl_in & ~sda_d_r & sda_in;
	wire rise_w  = scl_in & ~scl_d_r;
	wire fall_w  = ~scl_in & scl_d_r;

	assign sda_out      = 1'b0;
	assign sda_oe_out   = oe_r;
	assign reg_addr_out = ptr_r;
	assign wr_data_out  = sh_r;
	assign wr_stb_out   = stb_r;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			tx_r    <= 8'h00;
			ptr_r   <= 8'h00;
			rw_r    <= 1'b0;
			first_r <= 1'b1;
			nack_r  <= 1'b1;
			oe_r    <= 1'b0;
			stb_r   <= 1'b0;
		end else begin
			scl_d_r <= scl_in;
			sda_d_r <= sda_in;
			stb_r   <= 1'b0;
			if (start_w) begin
				state_r <= ST_ADDR;
				cnt_r   <= 4'h0;
				oe_r    <= 1'b0;
			end else if (stop_w) begin
				state_r <= ST_IDLE;
				oe_r    <= 1'b0;
			end else begin
				case (state_r)
				ST_ADDR, ST_WR: begin
					if (rise_w) begin
						sh_r  <= {sh_r[6:0], sda_in};
						cnt_r <= cnt_r + 4'h1;
					end else if (fall_w && cnt_r == `BBF_BIT_CNT_FULL) begin
						cnt_r <= 4'h0;
						if (state_r == ST_WR) begin
							oe_r    <= 1'b1;
							state_r <= ST_WACK;
							if (first_r)
								ptr_r <= sh_r;
							else
								stb_r <= 1'b1;
						end else if (sh_r[7:1] == `BBF_I2C_ADDR) begin
							oe_r    <= 1'b1;
							rw_r    <= sh_r[0];
							state_r <= ST_AACK;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (fall_w) begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							tx_r    <= rd_data_in;
							oe_r    <= ~rd_data_in[7];
							state_r <= ST_RD;
						end else begin
							oe_r    <= 1'b0;
							first_r <= 1'b1;
							state_r <= ST_WR;
						end
					end
				end
				ST_WACK: begin
					if (fall_w) begin
						oe_r    <= 1'b0;
						state_r <= ST_WR;
						first_r <= 1'b0;
						// The pointer byte itself must not advance the pointer
						if (!first_r)
							ptr_r <= ptr_r + 8'h01;
					end
				end
				ST_RD: begin
					if (fall_w) begin
						if (cnt_r == `BBF_BIT_CNT_LAST) begin
							oe_r    <= 1'b0;
							ptr_r   <= ptr_r + 8'h01;
							state_r <= ST_RACK;
						end else begin
							oe_r  <= ~tx_r[6];
							tx_r  <= {tx_r[6:0], 1'b0};
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (rise_w) begin
						nack_r <= sda_in;
					end else if (fall_w) begin
						cnt_r <= 4'h0;
						if (nack_r) begin
							state_r <= ST_IDLE;
						end else begin
							tx_r    <= rd_data_in;
							oe_r    <= ~rd_data_in[7];
							state_r <= ST_RD;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// File: bbf_config_top.v
// Frequency, protection and current limit configuration of a four-switch
// buck-boost controller, with its I2C register port.
// Assumes analog comparators deliver clean levels synchronous to CLOCK_IN.
`include "bbf_consts.vh"

// What this block does
// - Base frequency code 00/01/10/11 means 200/300/400/600 kHz.
// - Base frequency field is writable whether switching is enabled or not.
// - New base frequency is reached gradually; switching is never restarted.
// - Transition region runs at 62.5% of base when set, else 37.5%.
// - Over-current response acts after the cycle-by-cycle current limit trips.
// - Over-current code 00: no hiccup, no latch, only cycle limit.
// - Over-current code 01: hiccup on trip below 60% feedback; soft-start sets off time.
// - Over-current code 10: latch off until re-enable or power cycle.
// - Over-voltage response acts above 127% reference; code 11 reserved.
// - Over-voltage code 00: no action, no discharge, regulation continues.
// - Over-voltage code 01: stop and discharge above 127%, resume at 111%.
// - Over-voltage code 10: latch off without output discharge.
// - Current limit code selects 27.9 to 68.7 mV sense threshold.
// - Switching enable starts switching; cleared stops it, control keeps running.
module bbf_config_top (
	input  wire       CLOCK_IN,
	input  wire       RST_B_IN,
	input  wire       SCL_IN,
	input  wire       SDA_IN,
	output wire       SDA_OUT,
	output wire       SDA_OE_OUT,
	input  wire       SWITCHING_ENABLE_IN,
	input  wire       CUR_LIMIT_TRIP_IN,
	input  wire       FB_BELOW_60PCT_IN,
	input  wire       FB_ABOVE_127PCT_IN,
	input  wire       FB_BELOW_111PCT_IN,
	input  wire       TRANS_REGION_IN,
	input  wire       SS_DISCHARGED_IN,
	output wire       SWITCHING_ACTIVE_OUT,
	output wire       OUT_DISCHARGE_OUT,
	output wire       SS_DISCHARGE_OUT,
	output wire       FAULT_LATCHED_OUT,
	output wire [9:0] SW_FREQ_KHZ_OUT,
	output wire [9:0] AVG_AVERAGE_CURRENT_LIMIT_THRESH_OUT
);
	localparam ST_OFF    = 3'h0;
	localparam ST_RUN    = 3'h1;
	localparam ST_HICCUP = 3'h2;
	localparam ST_OV_DIS = 3'h3;
	localparam ST_LATCH  = 3'h4;

	wire [7:0] reg_addr;
	wire [7:0] wr_data;
	wire       wr_stb;
	reg  [7:0] rd_data;

	reg  [7:0] freq_prot_r;
	reg  [2:0] avg_average_current_limit_r;
	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [9:0] freq_r;
	reg  [9:0] target_nxt;
	reg  [`BBF_SLEW_CNT_W-1:0] slew_cnt_r;
	reg  [9:0] average_current_limit_r;
	reg        sw_act_r;
	reg        out_dis_r;
	reg        ss_dis_r;
	reg        latched_r;

	wire [1:0] base_freq_sel  = freq_prot_r[`BBF_F_BASE_FREQ];
	wire       transition_region_freq_sel = freq_prot_r[`BBF_F_TRANS_FREQ];
	wire [1:0] overcurrent_response = freq_prot_r[`BBF_F_OC_RESP];
	wire [1:0] overvoltage_response = freq_prot_r[`BBF_F_OV_RESP];
	wire [2:0] avg_current_limit_code = avg_average_current_limit_r;

	function [9:0] base_khz;
		input [1:0] code;
		begin
			case (code)
			2'h0:    base_khz = `BBF_KHZ_200;
			2'h1:    base_khz = `BBF_KHZ_300;
			2'h2:    base_khz = `BBF_KHZ_400;
			default: base_khz = `BBF_KHZ_600;
			endcase
		end
	endfunction

	// Scaling by 5/8 or 3/8 with a shift keeps the datapath free of a divider
	function [9:0] region_khz;
		input [9:0] base;
		input       hi;
		reg   [12:0] prod;
		begin
			prod = {3'h0, base} *
				(hi ? `BBF_TRANS_HI_MUL : `BBF_TRANS_LO_MUL);
			region_khz = prod[12:`BBF_TRANS_DIV_SH];
		end
	endfunction

	function [9:0] average_current_limit_thresh;
		input [2:0] code;
		begin
			case (code)
			3'h0:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_0;
			3'h1:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_1;
			3'h2:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_2;
			3'h3:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_3;
			3'h4:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_4;
			3'h5:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_5;
			3'h6:    average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_6;
			default: average_current_limit_thresh = `BBF_AVERAGE_CURRENT_LIMIT_7;
			endcase
		end
	endfunction

	bbf_i2c_slave u_i2c (
		.clk_in       (CLOCK_IN),
		.rst_b_in     (RST_B_IN),
		.scl_in       (SCL_IN),
		.sda_in       (SDA_IN),
		.sda_out      (SDA_OUT),
		.sda_oe_out   (SDA_OE_OUT),
		.reg_addr_out (reg_addr),
		.wr_data_out  (wr_data),
		.wr_stb_out   (wr_stb),
		.rd_data_in   (rd_data)
	);

	// Register writes; no gating by switching state
	always @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			freq_prot_r <= `BBF_FREQ_PROT_RST;
			avg_average_current_limit_r  <= `BBF_AVG_AVERAGE_CURRENT_LIMIT_RST;
		end else if (wr_stb) begin
			if (reg_addr == `BBF_REG_FREQ_PROT)
				freq_prot_r <= wr_data & `BBF_FREQ_PROT_WMASK;
			if (reg_addr == `BBF_REG_AVG_AVERAGE_CURRENT_LIMIT)
				avg_average_current_limit_r <= wr_data[`BBF_F_AVERAGE_CURRENT_LIMIT_CODE];
		end
	end

	// Unmapped offsets read as zero; unused bits read as zero
	always @* begin
		case (reg_addr)
		`BBF_REG_FREQ_PROT: rd_data = freq_prot_r;
		`BBF_REG_AVG_AVERAGE_CURRENT_LIMIT:  rd_data = {5'h00, avg_average_current_limit_r};
		default:            rd_data = `BBF_RD_ZERO;
		endcase
	end

	// Frequency target: base, or scaled base inside the transition region
	always @* begin
		target_nxt = base_khz(base_freq_sel);
		if (TRANS_REGION_IN)
			target_nxt = region_khz(target_nxt,
				transition_region_freq_sel);
	end

	// Slew one kHz per step so the loop never sees a frequency jump
	always @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			freq_r     <= `BBF_FREQ_RST_KHZ;
			slew_cnt_r <= {`BBF_SLEW_CNT_W{1'b0}};
		end else if (freq_r == target_nxt) begin
			slew_cnt_r <= {`BBF_SLEW_CNT_W{1'b0}};
		end else if (slew_cnt_r == `BBF_SLEW_LAST) begin
			slew_cnt_r <= {`BBF_SLEW_CNT_W{1'b0}};
			if (freq_r < target_nxt)
				freq_r <= freq_r + 10'h001;
			else
				freq_r <= freq_r - 10'h001;
		end else begin
			slew_cnt_r <= slew_cnt_r + {{(`BBF_SLEW_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Protection sequencer; over-voltage is checked ahead of over-current
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_OFF: begin
			if (SWITCHING_ENABLE_IN)
				state_nxt = ST_RUN;
		end
		ST_RUN: begin
			if (!SWITCHING_ENABLE_IN)
				state_nxt = ST_OFF;
			else if (FB_ABOVE_127PCT_IN &&
					overvoltage_response == `BBF_RESP_AUTO)
				state_nxt = ST_OV_DIS;
			else if (FB_ABOVE_127PCT_IN &&
					overvoltage_response == `BBF_RESP_LATCH)
				state_nxt = ST_LATCH;
			else if (CUR_LIMIT_TRIP_IN && FB_BELOW_60PCT_IN &&
					overcurrent_response == `BBF_RESP_AUTO)
				state_nxt = ST_HICCUP;
			else if (CUR_LIMIT_TRIP_IN &&
					overcurrent_response == `BBF_RESP_LATCH)
				state_nxt = ST_LATCH;
			// Codes 00 and reserved 11 leave the state alone
		end
		ST_HICCUP: begin
			if (!SWITCHING_ENABLE_IN)
				state_nxt = ST_OFF;
			else if (SS_DISCHARGED_IN)
				state_nxt = ST_RUN;
		end
		ST_OV_DIS: begin
			if (!SWITCHING_ENABLE_IN)
				state_nxt = ST_OFF;
			else if (FB_BELOW_111PCT_IN)
				state_nxt = ST_RUN;
		end
		ST_LATCH: begin
			// Only a re-enable (or reset) clears the latch
			if (!SWITCHING_ENABLE_IN)
				state_nxt = ST_OFF;
		end
		default: begin
			state_nxt = ST_OFF;
		end
		endcase
	end

	always @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_r   <= ST_OFF;
			sw_act_r  <= 1'b0;
			out_dis_r <= 1'b0;
			ss_dis_r  <= 1'b0;
			latched_r <= 1'b0;
			average_current_limit_r    <= `BBF_AVERAGE_CURRENT_LIMIT_1;
		end else begin
			state_r   <= state_nxt;
			sw_act_r  <= (state_nxt == ST_RUN);
			out_dis_r <= (state_nxt == ST_OV_DIS);
			ss_dis_r  <= (state_nxt == ST_HICCUP);
			latched_r <= (state_nxt == ST_LATCH);
			average_current_limit_r    <= average_current_limit_thresh(avg_current_limit_code);
		end
	end

	assign SWITCHING_ACTIVE_OUT = sw_act_r;
	assign OUT_DISCHARGE_OUT    = out_dis_r;
	assign SS_DISCHARGE_OUT     = ss_dis_r;
	assign FAULT_LATCHED_OUT    = latched_r;
	assign SW_FREQ_KHZ_OUT      = freq_r;
	assign AVG_AVERAGE_CURRENT_LIMIT_THRESH_OUT  = average_current_limit_r;
endmodule

// File: bbf_chk_sva.sv
// Checker for the protection state and frequency slew outputs.
// Bound into every bbf_config_top; sees only its ports.
module bbf_chk_sva (
	input wire       CLOCK_IN,
	input wire       RST_B_IN,
	input wire       SWITCHING_ENABLE_IN,
	input wire       CUR_LIMIT_TRIP_IN,
	input wire       FB_BELOW_60PCT_IN,
	input wire       FB_ABOVE_127PCT_IN,
	input wire       FB_BELOW_111PCT_IN,
	input wire       SS_DISCHARGED_IN,
	input wire       SWITCHING_ACTIVE_OUT,
	input wire       OUT_DISCHARGE_OUT,
	input wire       SS_DISCHARGE_OUT,
	input wire       FAULT_LATCHED_OUT,
	input wire [9:0] SW_FREQ_KHZ_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	AST_FREQ_STEP: assert property ($changed(SW_FREQ_KHZ_OUT) |->
		SW_FREQ_KHZ_OUT == $past(SW_FREQ_KHZ_OUT) + 10'h001 ||
		SW_FREQ_KHZ_OUT == $past(SW_FREQ_KHZ_OUT) - 10'h001)
		else $error("frequency jumped");
	AST_SLEW_PACE: assert property ($changed(SW_FREQ_KHZ_OUT) |=>
		$stable(SW_FREQ_KHZ_OUT) [*8]) else $error("slew too fast");
	AST_EN_OFF: assert property (!SWITCHING_ENABLE_IN |=>
		!SWITCHING_ACTIVE_OUT) else $error("switching while disabled");
	AST_OVP_CAUSE: assert property ($rose(OUT_DISCHARGE_OUT) |->
		$past(FB_ABOVE_127PCT_IN) && !SWITCHING_ACTIVE_OUT)
		else $error("discharge without overvoltage");
	AST_OVP_RESUME: assert property (OUT_DISCHARGE_OUT &&
		FB_BELOW_111PCT_IN |=> !OUT_DISCHARGE_OUT)
		else $error("discharge did not end");
	AST_LATCH_SAFE: assert property (FAULT_LATCHED_OUT |->
		!SWITCHING_ACTIVE_OUT && !OUT_DISCHARGE_OUT)
		else $error("latched but active");
	AST_LATCH_HOLD: assert property (FAULT_LATCHED_OUT &&
		SWITCHING_ENABLE_IN |=> FAULT_LATCHED_OUT)
		else $error("latch lost");
	AST_LATCH_CLEAR: assert property (FAULT_LATCHED_OUT &&
		!SWITCHING_ENABLE_IN |=> !FAULT_LATCHED_OUT)
		else $error("latch not cleared");
	AST_HICCUP_CAUSE: assert property ($rose(SS_DISCHARGE_OUT) |->
		$past(CUR_LIMIT_TRIP_IN && FB_BELOW_60PCT_IN))
		else $error("hiccup without cause");
	AST_HICCUP_END: assert property (SS_DISCHARGE_OUT &&
		SS_DISCHARGED_IN |=> !SS_DISCHARGE_OUT)
		else $error("hiccup did not end");
	COV_OVP: cover property ($rose(OUT_DISCHARGE_OUT));
	COV_LATCH: cover property ($rose(FAULT_LATCHED_OUT));
	COV_HICCUP: cover property ($rose(SS_DISCHARGE_OUT));
endmodule
bind bbf_config_top bbf_chk_sva bbf_chk_sva_i (.*);

// File: bbf_host_model.sv
// I2C host model that configures the converter registers.
// Assumes SDA is resolved outside with a pull-up; SCL is never stretched.
`include "bbf_consts.vh"
module bbf_host_model (
	input  wire  clk_in,
	input  wire  sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ack = 1'b0;
	int   nacks = 0;
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Five clocks per phase keeps above the target's oversampling need
	task gap;
		repeat (5) @(negedge clk_in);
	endtask
	task clk_bit(input logic b, output logic s);
		gap;
		sda_low_out = !b;
		gap;
		scl_out = 1'b1;
		gap;
		s = sda_in;
		scl_out = 1'b0;
	endtask
	task start;
		gap;
		sda_low_out = 1'b0;
		gap;
		scl_out = 1'b1;
		gap;
		sda_low_out = 1'b1;
		gap;
		scl_out = 1'b0;
	endtask
	task stop;
		gap;
		sda_low_out = 1'b1;
		gap;
		scl_out = 1'b1;
		gap;
		sda_low_out = 1'b0;
		gap;
	endtask
	task byte_out(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = !s;
		if (s)
			nacks++;
	endtask
	task byte_in(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(1'b1, s);
	endtask
	// Writes go out whatever the switching state is
	task wr(input logic [7:0] a, input logic [7:0] d);
		start;
		byte_out({`BBF_I2C_ADDR, 1'b0});
		byte_out(a);
		byte_out(d);
		stop;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		start;
		byte_out({`BBF_I2C_ADDR, 1'b0});
		byte_out(a);
		start;
		byte_out({`BBF_I2C_ADDR, 1'b1});
		byte_in(d);
		stop;
	endtask
endmodule

// File: tb.sv
// Self-checking bench for the frequency and protection configuration.
// Drives the analog status pins directly; the I2C host is a model.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       rst_b, en, trip, b60, a127, b111, trans, ssd;
	wire        scl, host_low, oe, sdo, act, odis, ssdis, lat;
	wire  [9:0] freq, average_current_limit;
	// Open drain: the pin pulls low only when enabled and driving 0
	wire        sda = !(host_low | (oe & !sdo));
	int         n_mismatch = 0;
	int         check_count = 0;
	initial forever #25 clk = ~clk;
	bbf_config_top bbf_config_top_i (
		.CLOCK_IN(clk),
		.RST_B_IN(rst_b),
		.SCL_IN(scl),
		.SDA_IN(sda),
		.SDA_OUT(sdo),
		.SDA_OE_OUT(oe),
		.SWITCHING_ENABLE_IN(en),
		.CUR_LIMIT_TRIP_IN(trip),
		.FB_BELOW_60PCT_IN(b60),
		.FB_ABOVE_127PCT_IN(a127),
		.FB_BELOW_111PCT_IN(b111),
		.TRANS_REGION_IN(trans),
		.SS_DISCHARGED_IN(ssd),
		.SWITCHING_ACTIVE_OUT(act),
		.OUT_DISCHARGE_OUT(odis),
		.SS_DISCHARGE_OUT(ssdis),
		.FAULT_LATCHED_OUT(lat),
		.SW_FREQ_KHZ_OUT(freq),
		.AVG_AVERAGE_CURRENT_LIMIT_THRESH_OUT(average_current_limit)
	);
	bbf_host_model bbf_host_model_i (
		.clk_in(clk),
		.sda_in(sda),
		.scl_out(scl),
		.sda_low_out(host_low)
	);
	task check(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		bbf_host_model_i.wr(a, d);
	endtask
	task rdchk(input logic [7:0] a, exp, input string nm);
		logic [7:0] d;
		bbf_host_model_i.rd(a, d);
		check(nm, d, exp);
	endtask
	task wait_freq(input logic [9:0] f);
		int i;
		for (i = 0; i < 10000 && freq !== f; i++)
			@(negedge clk);
		check("freq", freq, f);
		if (i == 10000)
			wrap_up;
	endtask
	// Order of v: above 127%, current trip, below 60%, soft-start empty
	task step(input logic [3:0] v, exp);
		{a127, trip, b60, ssd} = v;
		b111 = !v[3];
		repeat (3) @(negedge clk);
		check("state", {act, odis, ssdis, lat}, exp);
	endtask
	task t_reset;
		check("freq", freq, 10'h190);
		check("average_current_limit", average_current_limit, 10'h14D);
		rdchk(8'h03, 8'h85, "reg03");
		rdchk(8'h04, 8'h01, "reg04");
		rdchk(8'h07, 8'h00, "unmapped");
		bbf_host_model_i.start;
		bbf_host_model_i.byte_out(8'h56);
		check("foreign ack", bbf_host_model_i.ack, 1'b0);
		bbf_host_model_i.stop;
		$display("test reset done");
	endtask
	task t_freq;
		logic [9:0] f [4];
		f = '{10'h0C8, 10'h12C, 10'h190, 10'h258};
		en = 1'b0;
		wr(8'h03, 8'h25);
		rdchk(8'h03, 8'h05, "reg03 off");
		en = 1'b1;
		for (logic [2:0] i = 0; i < 4; i++) begin
			wr(8'h03, {i[1:0], 6'h05});
			check("slew", freq !== f[i], 1'b1);
			check("active", act, 1'b1);
			wait_freq(f[i]);
		end
		$display("test base frequency done");
	endtask
	task t_trans;
		trans = 1'b1;
		wr(8'h03, 8'hD5);
		wait_freq(10'h177);
		wr(8'h03, 8'hC5);
		wait_freq(10'h0E1);
		trans = 1'b0;
		wait_freq(10'h258);
		$display("test transition region done");
	endtask
	task t_average_current_limit;
		logic [9:0] lim [8];
		lim = '{10'h117, 10'h14D, 10'h189, 10'h1C3, 10'h200, 10'h238,
			10'h274, 10'h2AF};
		for (int i = 0; i < 8; i++) begin
			wr(8'h04, {5'h00, i[2:0]});
			repeat (2) @(negedge clk);
			check("average_current_limit", average_current_limit, lim[i]);
		end
		rdchk(8'h04, 8'h07, "reg04 last");
		$display("test current limit done");
	endtask
	// Codes in order none, auto, reserved, latch; the latch is last
	task t_prot(input logic ocp);
		logic [1:0] cd [4];
		logic [3:0] hi [4];
		cd = '{2'h0, 2'h1, 2'h3, 2'h2};
		hi = '{4'h8, ocp ? 4'h2 : 4'h4, 4'h8, 4'h1};
		if (ocp) begin
			wr(8'h03, 8'hC4);
			step(4'h4, 4'h8);
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h03, ocp ? {4'hC, cd[i], 2'h0} : {6'h30, cd[i]});
			step(ocp ? 4'h6 : 4'h8, hi[i]);
			step(ocp ? 4'h1 : 4'h0, i == 3 ? 4'h1 : 4'h8);
		end
		en = 1'b0;
		step(4'h0, 4'h0);
		en = 1'b1;
		step(4'h0, 4'h8);
		$display("test protection %0d done", ocp);
	endtask
	// Reset in mid-run must bring back the frequency, current limit and register defaults, not just the first time
	task t_mid_reset;
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		check("freq", freq, 10'h190);
		check("average_current_limit", average_current_limit, 10'h14D);
		rdchk(8'h03, 8'h85, "reg03 again");
		rdchk(8'h04, 8'h01, "reg04 again");
		$display("test mid-run reset done");
	endtask
	initial begin
		{rst_b, en, trip, b60, a127, b111, trans, ssd} = 8'h44;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		t_reset;
		t_freq;
		t_trans;
		t_average_current_limit;
		t_prot(1'b0);
		t_prot(1'b1);
		t_mid_reset;
		// Only the deliberate foreign address may go unanswered
		check("nacks", bbf_host_model_i.nacks, 16'h0001);
		wrap_up;
	end
endmodule
